/* File: rtl/gsc_pkg.sv */
// Shared constants, types and carriers for the gauge setpoint and emission control
package gsc_pkg;

  // Pressure code: hundredths of a decade above 1E-12 Torr, monotonic with pressure
  localparam int PR_W = 11;
  localparam logic [PR_W-1:0] THR_MIN       = 11'h064;  // 1.00E-11
  localparam logic [PR_W-1:0] THR_MAX       = 11'h418;  // 3.00E-02
  localparam logic [PR_W-1:0] ENGAGE_DEF    = 11'h258;  // 1.00E-06
  localparam logic [PR_W-1:0] RELEASE_DEF   = 11'h29E;  // 5.00E-06
  localparam logic [PR_W-1:0] AUTO_THR_MIN  = 11'h258;  // 1.00E-06
  localparam logic [PR_W-1:0] AUTO_THR_MAX  = 11'h320;  // 1.00E-04
  localparam logic [PR_W-1:0] AUTO_THR_DEF  = 11'h258;
  localparam logic [PR_W-1:0] OVP_LIMIT_MAX = 11'h42E;  // 5.00E-02
  localparam logic [PR_W-1:0] OVP_LIMIT_DEF = 11'h42E;
  localparam logic [PR_W-1:0] OVP_HIGH_EMIS = 11'h384;  // 1E-03, fixed at 4 mA

  // Outgas duration in whole minutes
  localparam logic [3:0] OUTGAS_MIN_LO  = 4'h2;
  localparam logic [3:0] OUTGAS_MIN_HI  = 4'hA;
  localparam logic [3:0] OUTGAS_MIN_DEF = 4'h2;

  // Sensitivity limits; the default stands in for the factory value
  localparam logic [6:0] SENS_LO  = 7'h02;
  localparam logic [6:0] SENS_HI  = 7'h63;
  localparam logic [6:0] SENS_DEF = 7'h0A;

  // Analog trim in signed millivolts; default stands in for the factory value
  localparam int TRIM_W = 12;
  localparam logic signed [TRIM_W-1:0] TRIM_DEF = 12'h000;
  localparam logic signed [TRIM_W-1:0] TRIM_MAX = 12'h7FF;
  localparam logic signed [TRIM_W-1:0] TRIM_MIN = 12'h800;

  // Timing
  localparam int CLK_PERIOD_NS   = 50;
  localparam int TICK_PERIOD_S   = 1;
  localparam int CYC_PER_SEC_DEF = TICK_PERIOD_S * 1_000_000_000 / CLK_PERIOD_NS;
  localparam int SEC_PER_MIN     = 60;
  localparam int SEC_PER_HOUR    = 3600;
  localparam int HOUR_W          = 16;

  // Setting selector for the write port
  typedef enum logic [3:0] {
    SEL_OUTGAS_MIN  = 4'h0,
    SEL_SENS        = 4'h1,
    SEL_FIL_CHOICE  = 4'h2,
    SEL_ENGAGE      = 4'h3,
    SEL_RELEASE     = 4'h4,
    SEL_RLY_TEST    = 4'h5,
    SEL_RLY_LEVEL   = 4'h6,
    SEL_AUTO_EN     = 4'h7,
    SEL_AUTO_THR    = 4'h8,
    SEL_OVP_LIMIT   = 4'h9,
    SEL_EMIS_4MA    = 4'hA
  } gsc_sel_t;

  // Filament control states, one-hot
  typedef enum logic [2:0] {
    FIL_OFF   = 3'b001,
    FIL_ON    = 3'b010,
    FIL_FAULT = 3'b100
  } gsc_fil_state_t;

  // Operator keys, active high while pressed
  typedef struct packed {
    logic filament_on;
    logic filament_off;
    logic outgas_on;
    logic outgas_off;
    logic trim_up;
    logic trim_down;
    logic trim_enter;
    logic clear_error;
  } gsc_keys_t;

  typedef struct packed {
    logic        en;
    gsc_sel_t    sel;
    logic [15:0] data;
  } gsc_wr_t;

  typedef struct packed {
    logic filament_on;
    logic filament_two;
    logic emis_4ma;
    logic outgas;
    logic relay;
    logic fault;
    logic wr_refused;
  } gsc_status_t;

endpackage : gsc_pkg

/* File: rtl/gsc_sync.sv */
// Three-stage synchroniser; a change counts once stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module gsc_sync #(
  parameter int W = 8
) (
  input  wire logic         i_clk,
  input  wire logic         i_resetn,
  input  wire logic         i_ce,
  input  wire logic [W-1:0] i_d,
  output logic      [W-1:0] o_q
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] q;
  } gsc_sync_st_t;

  gsc_sync_st_t st;
  gsc_sync_st_t next_st;

  // Stage one feeds stage two only; agreement filter looks at two and three
  always_comb begin
    next_st.s1 = i_d;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    next_st.q  = (st.s3 & ~(st.s2 ^ st.s3)) | (st.q & (st.s2 ^ st.s3));
  end

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      st <= '0;
    end else if (i_ce) begin
      st <= next_st;
    end
  end

  assign o_q = st.q;

endmodule : gsc_sync
`default_nettype wire

/* File: rtl/gsc_ctl.sv */
// Filament, emission, outgas, setpoint relay, hour meter and trim control
//
// Function
// [R1] Filament off at power-up; on/off confirm acts at once.
// [R2] Two emission settings, 4 mA and 100 uA; defaults restore 100 uA.
// [R3] Outgas starts only with filament on; outgas-off stops it at once.
// [R4] Outgas ends after programmed minutes, 2 to 10, default 2.
// [R5] Sensitivity held within 2 to 99 and passed to pressure computation.
// [R6] Operate filament chosen by setting; filament one by default.
// [R7] Engage below release: energize below engage, release above release.
// [R8] Engage above release: energize above engage, release below release.
// [R9] Relay thresholds accepted only within 1.00E-11 to 3.00E-02 Torr.
// [R10] Engage defaults to 1.00E-06, release to 5.00E-06 Torr.
// [R11] Relay manual check mode, off by default, sets relay regardless of pressure.
// [R12] Four hour meters: operating and outgas hours per filament, from zero.
// [R13] Auto emission switching off by default; threshold 1.00E-06 to 1.00E-04.
// [R14] Auto mode: 100 uA above threshold, 4 mA below it.
// [R15] Analog trim in mV stepped by keys, stored on confirm.
// [R16] Fault turns filament off and keeps it off until cleared.
// [R17] Overpressure trip: user limit up to 5.00E-02 at 100 uA, 1E-3 at 4 mA.
// [R18] Relay holds its state while pressure lies between thresholds.
`timescale 1ns/1ps
`default_nettype none
module gsc_ctl #(
  parameter int unsigned CYC_PER_SEC = gsc_pkg::CYC_PER_SEC_DEF
) (
  input  wire logic                                  i_clk,
  input  wire logic                                  i_resetn,
  input  wire logic                                  i_ce,
  input  wire gsc_pkg::gsc_keys_t                    i_keys,
  input  wire gsc_pkg::gsc_wr_t                      i_wr,
  input  wire logic                                  i_defaults,
  input  wire logic [gsc_pkg::PR_W-1:0]              i_pressure,
  input  wire logic                                  i_pressure_valid,
  input  wire logic                                  i_emission_fail,
  output gsc_pkg::gsc_status_t                       o_status,
  output logic [6:0]                                 o_sensitivity,
  output logic signed [gsc_pkg::TRIM_W-1:0]          o_trim_mv,
  output logic signed [gsc_pkg::TRIM_W-1:0]          o_trim_stored,
  output logic [3:0][gsc_pkg::HOUR_W-1:0]            o_hours
);
  import gsc_pkg::*;
  localparam int TICK_W = $clog2(CYC_PER_SEC + 1);
  typedef struct packed {
    gsc_fil_state_t                 fil;
    logic                           fil_two;
    logic                           emis_man_4ma;
    logic                           emis_auto_4ma;
    logic                           auto_en;
    logic [PR_W-1:0]                auto_thr;
    logic [PR_W-1:0]                ovp_limit;
    logic                           outgas;
    logic [9:0]                     outgas_left;
    logic [3:0]                     outgas_min;
    logic [6:0]                     sens;
    logic [PR_W-1:0]                engage;
    logic [PR_W-1:0]                release_thr;
    logic                           rly_test;
    logic                           relay;
    logic                           refused;
    logic signed [TRIM_W-1:0]       trim;
    logic signed [TRIM_W-1:0]       trim_saved;
    gsc_keys_t                      keys_prev;
    logic [TICK_W-1:0]              tick_cnt;
    logic [3:0][11:0]               secs;
    logic [3:0][HOUR_W-1:0]         hours;
  } gsc_st_t;
  gsc_st_t   st;
  gsc_st_t   next_st;
  gsc_keys_t keys_q;
  gsc_keys_t press;
  logic      tick;
  logic      measuring;
  logic      engage_low;
  logic [PR_W-1:0] trip_limit;
  logic [3:0] meter_run;
  logic [PR_W-1:0] wr_thr;
  // Keys arrive from panel pins, so they cross in through the synchroniser
  gsc_sync #(
    .W($bits(gsc_keys_t))
  ) u_key_sync (
    .i_clk    (i_clk),
    .i_resetn (i_resetn),
    .i_ce     (i_ce),
    .i_d      (i_keys),
    .o_q      (keys_q)
  );
  // Press pulses, one second tick and shared decode terms
  assign press      = keys_q & ~st.keys_prev;
  assign tick       = (st.tick_cnt == TICK_W'(CYC_PER_SEC - 1));
  assign measuring  = (st.fil == FIL_ON) && i_pressure_valid;
  assign engage_low = (st.engage < st.release_thr);
  assign wr_thr     = i_wr.data[PR_W-1:0];
  assign trip_limit = o_status.emis_4ma ? OVP_HIGH_EMIS : st.ovp_limit; // R17
  // Which meter runs: 0/1 operating hours, 2/3 outgas hours, per filament
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_meter
      assign meter_run[gi] = (st.fil == FIL_ON) && (st.fil_two == 1'(gi % 2))
                             && ((gi < 2) || st.outgas); // R12
    end
  endgenerate
  always_comb begin
    next_st           = st;
    next_st.keys_prev = keys_q;
    next_st.refused   = 1'b0;
    next_st.tick_cnt  = tick ? '0 : st.tick_cnt + TICK_W'(1);
    // Filament state machine; fault entry beats an off key in the same cycle
    case (st.fil)
      FIL_OFF: begin
        if (press.filament_on) begin
          next_st.fil = FIL_ON; // R1
        end
      end
      FIL_ON: begin
        if (i_emission_fail || (measuring && (i_pressure > trip_limit))) begin
          next_st.fil = FIL_FAULT; // R16 R17
        end else if (press.filament_off) begin
          next_st.fil = FIL_OFF; // R1
        end
      end
      FIL_FAULT: begin
        if (press.clear_error) begin
          next_st.fil = FIL_OFF; // R16
        end
      end
      default: begin
        next_st.fil = FIL_OFF;
      end
    endcase
    // Outgas runs only while the filament runs, ends on key or timeout
    if (next_st.fil != FIL_ON || press.outgas_off) begin
      next_st.outgas = 1'b0; // R3
    end else if (press.outgas_on && !st.outgas) begin
      next_st.outgas      = 1'b1; // R3
      next_st.outgas_left = 10'(st.outgas_min * SEC_PER_MIN); // R4
    end else if (st.outgas && tick) begin
      next_st.outgas_left = st.outgas_left - 10'h001;
      if (st.outgas_left == 10'h001) begin
        next_st.outgas = 1'b0; // R4
      end
    end
    // Auto emission follows pressure with a valid reading only
    if (measuring) begin
      if (i_pressure < st.auto_thr) begin
        next_st.emis_auto_4ma = 1'b1; // R14
      end else if (i_pressure > st.auto_thr) begin
        next_st.emis_auto_4ma = 1'b0; // R14
      end
    end
    // Setpoint relay with hysteresis in either direction
    if (!st.rly_test && measuring) begin
      if (engage_low) begin
        if (i_pressure < st.engage) begin
          next_st.relay = 1'b1; // R7
        end else if (i_pressure > st.release_thr) begin
          next_st.relay = 1'b0; // R7 R18
        end
      end else begin
        if (i_pressure > st.engage) begin
          next_st.relay = 1'b1; // R8
        end else if (i_pressure < st.release_thr) begin
          next_st.relay = 1'b0; // R8 R18
        end
      end
    end
    // Trim steps saturate so a held key cannot wrap the offset
    if (press.trim_up && st.trim != TRIM_MAX) begin
      next_st.trim = st.trim + 12'sh001; // R15
    end else if (press.trim_down && st.trim != TRIM_MIN) begin
      next_st.trim = st.trim - 12'sh001; // R15
    end
    if (press.trim_enter) begin
      next_st.trim_saved = st.trim; // R15
    end
    // Hour meters count whole hours of one second ticks
    if (tick) begin
      for (int m = 0; m < 4; m++) begin
        if (meter_run[m]) begin
          if (st.secs[m] == 12'(SEC_PER_HOUR - 1)) begin
            next_st.secs[m]  = 12'h000;
            next_st.hours[m] = st.hours[m] + HOUR_W'(1); // R12
          end else begin
            next_st.secs[m] = st.secs[m] + 12'h001;
          end
        end
      end
    end
    // Setting writes; out of range values are refused and flagged
    if (i_wr.en) begin
      case (i_wr.sel)
        SEL_OUTGAS_MIN: begin
          if (i_wr.data[3:0] >= OUTGAS_MIN_LO && i_wr.data[3:0] <= OUTGAS_MIN_HI
              && i_wr.data[15:4] == 12'h000) begin
            next_st.outgas_min = i_wr.data[3:0]; // R4
          end else begin
            next_st.refused = 1'b1;
          end
        end
        SEL_SENS: begin
          if (i_wr.data[6:0] >= SENS_LO && i_wr.data[6:0] <= SENS_HI
              && i_wr.data[15:7] == 9'h000) begin
            next_st.sens = i_wr.data[6:0]; // R5
          end else begin
            next_st.refused = 1'b1;
          end
        end
        SEL_FIL_CHOICE: next_st.fil_two = i_wr.data[0]; // R6
        SEL_ENGAGE, SEL_RELEASE: begin
          if (wr_thr >= THR_MIN && wr_thr <= THR_MAX && i_wr.data[15:PR_W] == 5'h00) begin
            if (i_wr.sel == SEL_ENGAGE) begin
              next_st.engage = wr_thr; // R9
            end else begin
              next_st.release_thr = wr_thr; // R9
            end
          end else begin
            next_st.refused = 1'b1;
          end
        end
        SEL_RLY_TEST: next_st.rly_test = i_wr.data[0]; // R11
        SEL_RLY_LEVEL: begin
          if (st.rly_test) begin
            next_st.relay = i_wr.data[0]; // R11
          end else begin
            next_st.refused = 1'b1;
          end
        end
        SEL_AUTO_EN: next_st.auto_en = i_wr.data[0]; // R13
        SEL_AUTO_THR: begin
          if (wr_thr >= AUTO_THR_MIN && wr_thr <= AUTO_THR_MAX
              && i_wr.data[15:PR_W] == 5'h00) begin
            next_st.auto_thr = wr_thr; // R13
          end else begin
            next_st.refused = 1'b1;
          end
        end
        SEL_OVP_LIMIT: begin
          if (wr_thr <= OVP_LIMIT_MAX && i_wr.data[15:PR_W] == 5'h00) begin
            next_st.ovp_limit = wr_thr; // R17
          end else begin
            next_st.refused = 1'b1;
          end
        end
        SEL_EMIS_4MA: next_st.emis_man_4ma = i_wr.data[0]; // R2
        default: next_st.refused = 1'b1;
      endcase
    end
    // Factory defaults override a write in the same cycle, except a relay level write; meters are kept
    if (i_defaults) begin
      next_st.emis_man_4ma = 1'b0; // R2
      next_st.outgas_min   = OUTGAS_MIN_DEF; // R4
      next_st.sens         = SENS_DEF;
      next_st.fil_two      = 1'b0; // R6
      next_st.engage       = ENGAGE_DEF; // R10
      next_st.release_thr  = RELEASE_DEF; // R10
      next_st.rly_test     = 1'b0; // R11
      next_st.auto_en      = 1'b0; // R13
      next_st.auto_thr     = AUTO_THR_DEF;
      next_st.ovp_limit    = OVP_LIMIT_DEF;
      next_st.refused      = 1'b0;
    end
  end
  // Reset brings up the filament off with every setting at its default
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      st             <= '0;
      st.fil         <= FIL_OFF; // R1
      st.outgas_min  <= OUTGAS_MIN_DEF;
      st.sens        <= SENS_DEF;
      st.engage      <= ENGAGE_DEF; // R10
      st.release_thr <= RELEASE_DEF; // R10
      st.auto_thr    <= AUTO_THR_DEF;
      st.ovp_limit   <= OVP_LIMIT_DEF;
      st.trim        <= TRIM_DEF;
      st.trim_saved  <= TRIM_DEF;
    end else if (i_ce) begin
      st <= next_st;
    end
  end
  // Outputs straight from state flops
  assign o_status.filament_on  = (st.fil == FIL_ON);
  assign o_status.filament_two = st.fil_two; // R6
  assign o_status.emis_4ma     = st.auto_en ? st.emis_auto_4ma : st.emis_man_4ma; // R2 R14
  assign o_status.outgas       = st.outgas;
  assign o_status.relay        = st.relay;
  assign o_status.fault        = (st.fil == FIL_FAULT);
  assign o_status.wr_refused   = st.refused;
  assign o_sensitivity         = st.sens; // R5
  assign o_trim_mv             = st.trim;
  assign o_trim_stored         = st.trim_saved;
  assign o_hours               = st.hours;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_resetn);
  sequence s_on_cmd;
    i_ce && st.fil == FIL_OFF && press.filament_on;
  endsequence
  sequence s_fault_hit;
    i_ce && st.fil == FIL_ON && i_emission_fail;
  endsequence
  fil_on_cmd_a: assert property (s_on_cmd |=> o_status.filament_on) // R1
    else $error("filament did not start on confirm");
  emis_default_a: assert property (i_ce && i_defaults |=> !st.emis_man_4ma) // R2
    else $error("defaults did not restore 100 uA");
  outgas_needs_on_a: assert property (o_status.outgas |-> o_status.filament_on) // R3
    else $error("outgas without filament");
  outgas_stop_a: assert property (i_ce && press.outgas_off |=> !o_status.outgas) // R3
    else $error("outgas did not stop");
  outgas_range_a: assert property (st.outgas_min inside {[OUTGAS_MIN_LO:OUTGAS_MIN_HI]}) // R4
    else $error("outgas minutes out of range");
  sens_range_a: assert property (o_sensitivity >= SENS_LO && o_sensitivity <= SENS_HI) // R5
    else $error("sensitivity out of range");
  relay_fall_a: assert property (i_ce && !st.rly_test && measuring && engage_low // R7
                                 && i_pressure < st.engage |=> o_status.relay)
    else $error("relay not energized below engage");
  relay_rise_a: assert property (i_ce && !st.rly_test && measuring && !engage_low // R8
                                 && i_pressure > st.engage |=> o_status.relay)
    else $error("relay not energized above engage");
  thr_range_a: assert property (st.engage >= THR_MIN && st.engage <= THR_MAX // R9
                                && st.release_thr >= THR_MIN && st.release_thr <= THR_MAX)
    else $error("relay threshold out of range");
  relay_test_a: assert property (i_ce && st.rly_test && i_wr.en && i_wr.sel == SEL_RLY_LEVEL // R11
                                 && !i_defaults |=> o_status.relay == $past(i_wr.data[0]))
    else $error("manual relay level not applied");
  relay_hold_a: assert property (i_ce && !st.rly_test && measuring && engage_low // R18
                                 && i_pressure >= st.engage
                                 && i_pressure <= st.release_thr |=> $stable(o_status.relay))
    else $error("relay changed between thresholds");
  auto_sw_a: assert property (i_ce && st.auto_en && !i_defaults && measuring // R14
                              && i_pressure < st.auto_thr ##1 st.auto_en |-> o_status.emis_4ma)
    else $error("auto emission did not select 4 mA");
  fault_hold_a: assert property (s_fault_hit |=> o_status.fault && !o_status.filament_on // R16
                                 ##1 (!o_status.filament_on)[*2])
    else $error("filament not held off after fault");
  ovp_trip_a: assert property (i_ce && measuring && o_status.emis_4ma // R17
                               && i_pressure > OVP_HIGH_EMIS |=> o_status.fault)
    else $error("4 mA overpressure trip missed");

endmodule : gsc_ctl
`default_nettype wire

/* File: test/gsc_relay_load.sv */
// Model of the external circuit wired to the setpoint relay contacts
`timescale 1ns/1ps
`default_nettype none
module gsc_relay_load (
  input  wire logic i_clk,
  input  wire logic i_resetn,
  input  wire logic i_relay,
  output logic      o_closed
);
  logic [1:0] settle;
  // Contacts report a change three cycles late, like a coil pulling in
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      settle   <= 2'h0;
      o_closed <= 1'b0;
    end else begin
      settle   <= {settle[0], i_relay};
      o_closed <= settle[1];
    end
  end
endmodule : gsc_relay_load
`default_nettype wire

/* File: test/tb_gsc_ctl.sv */
// Self-checking bench for the gauge setpoint and emission control
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin n_fail++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (e)); end end
module tb_gsc_ctl;
  import gsc_pkg::*;
  // Short second so the outgas and hour counts fit the run
  localparam int CPS = 10;
  logic                     i_clk;
  logic                     i_resetn;
  logic                     ce;
  logic                     pv;
  logic                     efail;
  logic                     dflt;
  logic [PR_W-1:0]          pr;
  gsc_keys_t                keys;
  gsc_wr_t                  wr;
  gsc_status_t              st;
  logic [6:0]               sens;
  logic signed [TRIM_W-1:0] trim;
  logic signed [TRIM_W-1:0] trim_st;
  logic [3:0][HOUR_W-1:0]   hours;
  logic                     closed;
  int                       n_fail;
  int                       checks_done;
  int                       cyc;

  gsc_ctl #(.CYC_PER_SEC(CPS)) gsc_ctl_inst (.i_clk(i_clk), .i_resetn(i_resetn), .i_ce(ce),
    .i_keys(keys), .i_wr(wr), .i_defaults(dflt), .i_pressure(pr), .i_pressure_valid(pv),
    .i_emission_fail(efail), .o_status(st), .o_sensitivity(sens), .o_trim_mv(trim),
    .o_trim_stored(trim_st), .o_hours(hours));
  gsc_relay_load gsc_relay_load_inst (.i_clk(i_clk), .i_resetn(i_resetn), .i_relay(st.relay),
    .o_closed(closed));

  // Clock, 50 ns period
  initial begin
    i_clk = 1'b0;
    forever #25 i_clk = ~i_clk;
  end

  // Verdict and end of run
  task automatic results();
    $display("checks=%0d mismatches=%0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : results

  // Hang guard, well above the hour-meter wait
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (cyc == 45000) begin
      n_fail++;
      results();
    end
  end

  // Key held long enough to pass the synchroniser, then released
  task automatic press(input int k);
    @(posedge i_clk) keys <= gsc_keys_t'(8'h80 >> k);
    repeat (6) @(posedge i_clk);
    keys <= '0;
    repeat (6) @(posedge i_clk);
    #1;
  endtask : press

  // One-cycle setting strobe; refusal shows the cycle after it is taken
  task automatic wr_set(input gsc_sel_t s, input logic [15:0] d, input logic ref_exp);
    @(posedge i_clk) wr <= '{en: 1'b1, sel: s, data: d};
    @(posedge i_clk) wr.en <= 1'b0;
    #1;
    `CHK(st.wr_refused, ref_exp)
  endtask : wr_set

  task automatic setp(input int v);
    @(posedge i_clk) pr <= PR_W'(v);
    repeat (3) @(posedge i_clk);
    #1;
  endtask : setp

  // Relay output and the far circuit both checked, after contact settling
  task automatic chk_relay(input logic e);
    repeat (4) @(posedge i_clk);
    #1;
    `CHK(st.relay, e)
    `CHK(closed, e)
  endtask : chk_relay

  task automatic pulse_dflt();
    @(posedge i_clk) dflt <= 1'b1;
    @(posedge i_clk) dflt <= 1'b0;
    #1;
  endtask : pulse_dflt

  // Main sequence; pressure starts between the default thresholds
  initial begin
    i_resetn = 1'b0;
    keys = '0;
    wr = '0;
    dflt = 1'b0;
    efail = 1'b0;
    pv = 1'b1;
    pr = 11'h27B;
    n_fail = 0;
    checks_done = 0;
    ce = 1'b1;
    repeat (10) @(posedge i_clk);
    i_resetn <= 1'b1;
    #1;
    `CHK(st, 7'h00)
    `CHK(sens, SENS_DEF)
    `CHK({trim, trim_st}, 24'h000000)
    `CHK(hours, 64'h0)
    $display("done: reset");
    press(2);
    `CHK(st.outgas, 1'b0)
    press(0);
    `CHK(st.filament_on, 1'b1)
    chk_relay(1'b0);
    setp(500);
    chk_relay(1'b1);
    setp(635);
    chk_relay(1'b1);
    setp(671);
    chk_relay(1'b0);
    $display("done: relay low-engage");
    wr_set(SEL_ENGAGE, 16'h0063, 1'b1);
    wr_set(SEL_RELEASE, 16'h0419, 1'b1);
    wr_set(SEL_ENGAGE, 16'h0418, 1'b0);
    wr_set(SEL_RELEASE, 16'h0064, 1'b0);
    setp(1060);
    chk_relay(1'b1);
    setp(500);
    chk_relay(1'b1);
    setp(99);
    chk_relay(1'b0);
    $display("done: relay high-engage");
    setp(1070);
    `CHK(st.fault, 1'b0)
    setp(1071);
    `CHK({st.fault, st.filament_on}, 2'b10)
    press(0);
    `CHK(st.filament_on, 1'b0)
    setp(500);
    press(7);
    press(0);
    `CHK({st.fault, st.filament_on}, 2'b01)
    wr_set(SEL_OVP_LIMIT, 16'h042F, 1'b1);
    wr_set(SEL_OVP_LIMIT, 16'h0320, 1'b0);
    setp(800);
    `CHK(st.fault, 1'b0)
    setp(801);
    `CHK({st.fault, st.filament_on}, 2'b10)
    setp(500);
    press(7);
    press(0);
    wr_set(SEL_EMIS_4MA, 16'h0001, 1'b0);
    `CHK(st.emis_4ma, 1'b1)
    setp(901);
    `CHK({st.fault, st.filament_on}, 2'b10)
    setp(99);
    press(7);
    press(0);
    @(posedge i_clk) efail <= 1'b1;
    repeat (2) @(posedge i_clk);
    efail <= 1'b0;
    setp(99);
    `CHK({st.fault, st.filament_on}, 2'b10)
    press(7);
    press(0);
    chk_relay(1'b0);
    $display("done: faults");
    setp(640);
    pulse_dflt();
    `CHK(st.emis_4ma, 1'b0)
    setp(599);
    chk_relay(1'b1);
    setp(669);
    chk_relay(1'b1);
    setp(671);
    chk_relay(1'b0);
    $display("done: defaults");
    wr_set(SEL_RLY_LEVEL, 16'h0001, 1'b1);
    wr_set(SEL_RLY_TEST, 16'h0001, 1'b0);
    wr_set(SEL_RLY_LEVEL, 16'h0001, 1'b0);
    chk_relay(1'b1);
    wr_set(SEL_RLY_LEVEL, 16'h0000, 1'b0);
    setp(500);
    chk_relay(1'b0);
    wr_set(SEL_RLY_TEST, 16'h0000, 1'b0);
    chk_relay(1'b1);
    $display("done: relay test");
    // Clock enable low freezes the relay although pressure crosses release
    @(posedge i_clk) ce <= 1'b0;
    setp(671);
    chk_relay(1'b1);
    @(posedge i_clk) ce <= 1'b1;
    chk_relay(1'b0);
    wr_set(SEL_AUTO_THR, 16'h0257, 1'b1);
    wr_set(SEL_AUTO_THR, 16'h0321, 1'b1);
    wr_set(SEL_AUTO_THR, 16'h02BC, 1'b0);
    setp(650);
    `CHK(st.emis_4ma, 1'b0)
    wr_set(SEL_AUTO_EN, 16'h0001, 1'b0);
    setp(650);
    `CHK(st.emis_4ma, 1'b1)
    setp(710);
    `CHK(st.emis_4ma, 1'b0)
    wr_set(SEL_AUTO_EN, 16'h0000, 1'b0);
    $display("done: auto emission");
    wr_set(SEL_SENS, 16'h0001, 1'b1);
    wr_set(SEL_SENS, 16'h0064, 1'b1);
    wr_set(SEL_SENS, 16'h0063, 1'b0);
    `CHK(sens, 7'h63)
    wr_set(SEL_OUTGAS_MIN, 16'h000B, 1'b1);
    wr_set(SEL_OUTGAS_MIN, 16'h0001, 1'b1);
    wr_set(SEL_OUTGAS_MIN, 16'h0002, 1'b0);
    press(2);
    `CHK(st.outgas, 1'b1)
    press(3);
    `CHK(st.outgas, 1'b0)
    press(2);
    repeat (1100) @(posedge i_clk);
    #1;
    `CHK(st.outgas, 1'b1)
    repeat (150) @(posedge i_clk);
    #1;
    `CHK(st.outgas, 1'b0)
    $display("done: outgas");
    press(4);
    press(4);
    `CHK(trim > 0, 1'b1)
    `CHK(trim_st, TRIM_DEF)
    press(6);
    `CHK(trim_st > 0, 1'b1)
    press(5);
    press(5);
    `CHK(trim, TRIM_DEF)
    press(6);
    `CHK(trim_st, TRIM_DEF)
    $display("done: trim");
    wr_set(SEL_FIL_CHOICE, 16'h0001, 1'b0);
    `CHK(st.filament_two, 1'b1)
    repeat (36100) @(posedge i_clk);
    #1;
    `CHK(hours[1], 16'h0001)
    `CHK(hours[0], 16'h0000)
    $display("done: hour meters");
    results();
  end
endmodule : tb_gsc_ctl
`default_nettype wire
